// file: rtl/video_feature_pkg.sv
// Behaviour
// - Writing 1 to white_balance_start starts balancing; reads 1 while running.
// - Writing 0 to white_balance_start is ignored and never aborts balancing.
// - white_balance_start reads 0 whenever balancing is not running.
// - gamma_enable 1 sends RGB video through the 256-entry gamma table.
// - luma_filter_disable 1 bypasses the luma peaking filter.
// - odd_field_blue_first picks blue or red for the odd field's first line.
// - even_field_blue_first picks blue or red for the even field's first line.
// - pixel_phase 1 makes the first pixel positive, 0 negative.
// - Outputs drive only when output enable bit and pin are both 1.
// - external_reference_select 1 takes timing from reference pins only.
// - external_reference_select 0 follows embedded EAV/SAV codes from the imager.
// - clip_relax 1 excludes only 00 and FF; 0 limits to BT.601 ranges.
// - red_balance_value scales red in R-Y, minimum 00h, maximum FFh.
// - During balancing the device adjusts red balance to minimise |R-Y|.
// - During balancing the device adjusts blue balance to minimise |B-Y|.
package video_feature_pkg;
    localparam logic [7:0] FEATURE_CONTROL_ADDR   = 8'h05;
    localparam logic [7:0] OPERATIONAL_CTRL_ADDR  = 8'h06;
    localparam logic [7:0] OPERATIONAL_CTRL2_ADDR = 8'h07;
    localparam logic [7:0] RED_BALANCE_ADDR       = 8'h08;
    localparam logic [7:0] BLUE_BALANCE_ADDR      = 8'h09;

    localparam int WB_START_BIT      = 1;
    localparam int GAMMA_BIT         = 2;
    localparam int LUMA_OFF_BIT      = 3;
    localparam int CHROMA_OFF_BIT    = 4;
    localparam int ODD_BLUE_BIT      = 0;
    localparam int EVEN_BLUE_BIT     = 1;
    localparam int PIXEL_PHASE_BIT   = 2;
    localparam int OUTPUT_ENABLE_BIT = 3;
    localparam int EXT_REF_BIT       = 4;
    localparam int CLIP_RELAX_BIT    = 6;
    localparam int FACTORY_TEST_BIT  = 7;

    localparam logic [7:0] FEATURE_STORE_MASK = 8'h1C;
    localparam logic [7:0] OPCTL_STORE_MASK   = 8'h1F;
    localparam logic [7:0] OPCTL2_STORE_MASK  = 8'hC0;

    localparam logic [7:0] FEATURE_RESET = 8'h00;
    localparam logic [7:0] OPCTL_RESET   = 8'h00;
    localparam logic [7:0] OPCTL2_RESET  = 8'h00;
    localparam logic [7:0] BALANCE_RESET = 8'h00;

    localparam logic [7:0] CODE_BLACK      = 8'h10;
    localparam logic [7:0] CODE_LUMA_MAX   = 8'hEB;
    localparam logic [7:0] CODE_CHROMA_MAX = 8'hF0;
    localparam logic [7:0] CODE_RELAX_MIN  = 8'h01;
    localparam logic [7:0] CODE_RELAX_MAX  = 8'hFE;
    localparam logic [7:0] CODE_FORBID_LO  = 8'h00;
    localparam logic [7:0] CODE_FORBID_HI  = 8'hFF;

    localparam logic [7:0] SYNC_PREAMBLE_FF = 8'hFF;
    localparam logic [7:0] SYNC_PREAMBLE_00 = 8'h00;
    localparam int XY_FIELD_BIT  = 6;
    localparam int XY_VBLANK_BIT = 5;
    localparam int XY_HBLANK_BIT = 4;

    localparam logic [7:0] BALANCE_MIN   = 8'h00;
    localparam logic [7:0] BALANCE_MAX   = 8'hFF;
    localparam logic [7:0] AWB_TOLERANCE = 8'h02;
    localparam logic [7:0] AWB_MAX_STEPS = 8'hFF;

    typedef enum logic [1:0] {
        AWB_IDLE    = 2'b00,
        AWB_MEASURE = 2'b01,
        AWB_SETTLE  = 2'b11
    } awb_state_e;
endpackage : video_feature_pkg

// file: rtl/awb_if.sv
`timescale 1ns/1ps
interface awb_if;
    logic start;
    logic busy;
    logic red_up;
    logic red_down;
    logic blue_up;
    logic blue_down;
    modport engine (input start, output busy, output red_up,
                    output red_down, output blue_up, output blue_down);
    modport regs (output start, input busy, input red_up,
                  input red_down, input blue_up, input blue_down);
endinterface : awb_if

// file: rtl/white_balance_engine.sv
`timescale 1ns/1ps
module white_balance_engine (
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    awb_if.engine                  ctl,
    input  wire logic              measure_i,
    input  wire logic signed [7:0] r_minus_y_i,
    input  wire logic signed [7:0] b_minus_y_i,
    input  wire logic        [7:0] red_value_i,
    input  wire logic        [7:0] blue_value_i
);
    video_feature_pkg::awb_state_e state_reg;
    logic [7:0] steps_reg;
    logic [7:0] r_mag;
    logic [7:0] b_mag;
    logic       r_off;
    logic       b_off;

    function automatic logic [7:0] magnitude(input logic signed [7:0] x);
        magnitude = x[7] ? (~x + 8'h01) : x;
    endfunction : magnitude

    assign r_mag = magnitude(r_minus_y_i);
    assign b_mag = magnitude(b_minus_y_i);
    assign r_off = r_mag > video_feature_pkg::AWB_TOLERANCE;
    assign b_off = b_mag > video_feature_pkg::AWB_TOLERANCE;
    assign ctl.busy = state_reg != video_feature_pkg::AWB_IDLE;

    // One step per measurement keeps the loop stable on noisy fields
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            state_reg <= video_feature_pkg::AWB_IDLE;
            steps_reg <= 8'h00;
        end
        else
        begin
            case (state_reg)
                video_feature_pkg::AWB_IDLE:
                begin
                    steps_reg <= 8'h00;
                    if (ctl.start)
                        state_reg <= video_feature_pkg::AWB_MEASURE;
                end
                video_feature_pkg::AWB_MEASURE:
                begin
                    if (measure_i)
                    begin
                        steps_reg <= steps_reg + 8'h01;
                        if ((!r_off && !b_off) ||
                            steps_reg == video_feature_pkg::AWB_MAX_STEPS)
                            state_reg <= video_feature_pkg::AWB_IDLE;
                        else
                            state_reg <= video_feature_pkg::AWB_SETTLE;
                    end
                end
                default:
                    state_reg <= video_feature_pkg::AWB_MEASURE;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            ctl.red_up    <= 1'b0;
            ctl.red_down  <= 1'b0;
            ctl.blue_up   <= 1'b0;
            ctl.blue_down <= 1'b0;
        end
        else
        begin
            ctl.red_up    <= 1'b0;
            ctl.red_down  <= 1'b0;
            ctl.blue_up   <= 1'b0;
            ctl.blue_down <= 1'b0;
            if (state_reg == video_feature_pkg::AWB_MEASURE && measure_i)
            begin
                // Positive R-Y means too much red
                if (r_off && !r_minus_y_i[7] &&
                    red_value_i != video_feature_pkg::BALANCE_MIN)
                    ctl.red_down <= 1'b1;
                if (r_off && r_minus_y_i[7] &&
                    red_value_i != video_feature_pkg::BALANCE_MAX)
                    ctl.red_up <= 1'b1;
                if (b_off && !b_minus_y_i[7] &&
                    blue_value_i != video_feature_pkg::BALANCE_MIN)
                    ctl.blue_down <= 1'b1;
                if (b_off && b_minus_y_i[7] &&
                    blue_value_i != video_feature_pkg::BALANCE_MAX)
                    ctl.blue_up <= 1'b1;
            end
        end
    end

    property p_red_tracks;
        @(posedge clock_i) disable iff (rst_i)
        state_reg == video_feature_pkg::AWB_MEASURE && measure_i && r_off
            && !r_minus_y_i[7] && red_value_i != 8'h00 |=> ctl.red_down;
    endproperty
    a_red_tracks: assert property (p_red_tracks)
        else $error("red balance not lowered on positive R-Y");

    property p_blue_tracks;
        @(posedge clock_i) disable iff (rst_i)
        state_reg == video_feature_pkg::AWB_MEASURE && measure_i && b_off
            && b_minus_y_i[7] && blue_value_i != 8'hFF |=> ctl.blue_up;
    endproperty
    a_blue_tracks: assert property (p_blue_tracks)
        else $error("blue balance not raised on negative B-Y");
endmodule : white_balance_engine

// file: rtl/video_feature_control_regs.sv
`timescale 1ns/1ps
module video_feature_control_regs (
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    input  wire logic        [7:0] reg_addr_i,
    input  wire logic        [7:0] reg_wdata_i,
    input  wire logic              reg_write_i,
    input  wire logic              reg_read_i,
    output logic             [7:0] reg_rdata_o,
    output logic                   gamma_enable_o,
    output logic                   luma_filter_disable_o,
    output logic                   chroma_filter_disable_o,
    output logic                   first_line_blue_o,
    output logic                   pixel_phase_o,
    output logic             [7:0] red_balance_value_o,
    output logic             [7:0] blue_balance_value_o,
    input  wire logic        [7:0] imager_data_i,
    input  wire logic              horizontal_reference_input_i,
    input  wire logic              vertical_reference_input_i,
    input  wire logic              high_impedance_control_pin_i,
    output logic                   h_timing_o,
    output logic                   v_timing_o,
    output logic                   field_o,
    input  wire logic        [7:0] video_data_i,
    input  wire logic              video_is_chroma_i,
    output logic             [7:0] video_data_o,
    output logic                   video_data_oe_n_o,
    input  wire logic              measure_i,
    input  wire logic signed [7:0] r_minus_y_i,
    input  wire logic signed [7:0] b_minus_y_i
);
    logic [7:0] feature_reg;
    logic [7:0] opctl_reg;
    logic [7:0] opctl2_reg;
    logic [7:0] red_reg;
    logic [7:0] blue_reg;
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic       vref_last_reg;
    logic       ext_field_reg;
    logic [7:0] hist0_reg;
    logic [7:0] hist1_reg;
    logic [7:0] hist2_reg;
    logic       emb_h_reg;
    logic       emb_v_reg;
    logic       emb_f_reg;
    logic       write_feature;
    logic       ext_ref;
    logic       h_ref_sync;
    logic       vref_sync;
    logic       hiz_sync;
    logic       sync_seen;

    awb_if awb ();

    white_balance_engine engine (
        .clock_i      (clock_i),
        .rst_i        (rst_i),
        .ctl          (awb.engine),
        .measure_i    (measure_i),
        .r_minus_y_i  (r_minus_y_i),
        .b_minus_y_i  (b_minus_y_i),
        .red_value_i  (red_reg),
        .blue_value_i (blue_reg)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = a == b;
    endfunction : hit

    function automatic logic [7:0] limit(input logic [7:0] v,
                                         input logic [7:0] lo,
                                         input logic [7:0] hi);
        if (v < lo)
            limit = lo;
        else if (v > hi)
            limit = hi;
        else
            limit = v;
    endfunction : limit

    assign write_feature = reg_write_i &&
        hit(reg_addr_i, video_feature_pkg::FEATURE_CONTROL_ADDR);
    // A zero write never reaches the engine, so it cannot abort a run
    assign awb.start = write_feature && !awb.busy &&
        reg_wdata_i[video_feature_pkg::WB_START_BIT];

    // Store only documented bits; reserved stay zero
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            feature_reg <= video_feature_pkg::FEATURE_RESET;
            opctl_reg   <= video_feature_pkg::OPCTL_RESET;
            opctl2_reg  <= video_feature_pkg::OPCTL2_RESET;
        end
        else if (reg_write_i)
        begin
            if (write_feature)
                feature_reg <= reg_wdata_i &
                    video_feature_pkg::FEATURE_STORE_MASK;
            else if (hit(reg_addr_i, video_feature_pkg::OPERATIONAL_CTRL_ADDR))
                opctl_reg <= reg_wdata_i &
                    video_feature_pkg::OPCTL_STORE_MASK;
            else if (hit(reg_addr_i,
                         video_feature_pkg::OPERATIONAL_CTRL2_ADDR))
                opctl2_reg <= reg_wdata_i &
                    video_feature_pkg::OPCTL2_STORE_MASK;
        end
    end

    // Host write wins over an engine step in the same cycle
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            red_reg <= video_feature_pkg::BALANCE_RESET;
        else if (reg_write_i &&
                 hit(reg_addr_i, video_feature_pkg::RED_BALANCE_ADDR))
            red_reg <= reg_wdata_i;
        else if (awb.red_up)
            red_reg <= red_reg + 8'h01;
        else if (awb.red_down)
            red_reg <= red_reg - 8'h01;
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            blue_reg <= video_feature_pkg::BALANCE_RESET;
        else if (reg_write_i &&
                 hit(reg_addr_i, video_feature_pkg::BLUE_BALANCE_ADDR))
            blue_reg <= reg_wdata_i;
        else if (awb.blue_up)
            blue_reg <= blue_reg + 8'h01;
        else if (awb.blue_down)
            blue_reg <= blue_reg - 8'h01;
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            reg_rdata_o <= 8'h00;
        else if (reg_read_i)
        begin
            if (hit(reg_addr_i, video_feature_pkg::FEATURE_CONTROL_ADDR))
                reg_rdata_o <= feature_reg |
                    {6'h00, awb.busy, 1'b0};
            else if (hit(reg_addr_i, video_feature_pkg::OPERATIONAL_CTRL_ADDR))
                reg_rdata_o <= opctl_reg;
            else if (hit(reg_addr_i,
                         video_feature_pkg::OPERATIONAL_CTRL2_ADDR))
                reg_rdata_o <= opctl2_reg;
            else if (hit(reg_addr_i, video_feature_pkg::RED_BALANCE_ADDR))
                reg_rdata_o <= red_reg;
            else if (hit(reg_addr_i, video_feature_pkg::BLUE_BALANCE_ADDR))
                reg_rdata_o <= blue_reg;
            else
                reg_rdata_o <= 8'h00;
        end
    end

    assign gamma_enable_o =
        feature_reg[video_feature_pkg::GAMMA_BIT];
    assign luma_filter_disable_o =
        feature_reg[video_feature_pkg::LUMA_OFF_BIT];
    assign chroma_filter_disable_o =
        feature_reg[video_feature_pkg::CHROMA_OFF_BIT];
    assign pixel_phase_o =
        opctl_reg[video_feature_pkg::PIXEL_PHASE_BIT];
    assign first_line_blue_o = field_o ?
        opctl_reg[video_feature_pkg::EVEN_BLUE_BIT] :
        opctl_reg[video_feature_pkg::ODD_BLUE_BIT];
    assign red_balance_value_o  = red_reg;
    assign blue_balance_value_o = blue_reg;
    assign ext_ref = opctl_reg[video_feature_pkg::EXT_REF_BIT];

    // Pins cross into the clock domain: both references, high-impedance pin
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
        end
        else
        begin
            pin_meta_reg <= {high_impedance_control_pin_i,
                             vertical_reference_input_i,
                             horizontal_reference_input_i};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    assign h_ref_sync = pin_sync_reg[0];
    assign vref_sync = pin_sync_reg[1];
    assign hiz_sync  = pin_sync_reg[2];

    // Field from pins toggles on each vref rise
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            vref_last_reg <= 1'b0;
            ext_field_reg <= 1'b0;
        end
        else
        begin
            vref_last_reg <= vref_sync;
            if (vref_sync && !vref_last_reg)
                ext_field_reg <= !ext_field_reg;
        end
    end

    // Imager bus is synchronous to clock_i
    assign sync_seen =
        hit(hist2_reg, video_feature_pkg::SYNC_PREAMBLE_FF) &&
        hit(hist1_reg, video_feature_pkg::SYNC_PREAMBLE_00) &&
        hit(hist0_reg, video_feature_pkg::SYNC_PREAMBLE_00);

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            hist0_reg <= 8'h00;
            hist1_reg <= 8'h00;
            hist2_reg <= 8'h00;
            emb_h_reg <= 1'b0;
            emb_v_reg <= 1'b0;
            emb_f_reg <= 1'b0;
        end
        else
        begin
            hist0_reg <= imager_data_i;
            hist1_reg <= hist0_reg;
            hist2_reg <= hist1_reg;
            if (sync_seen)
            begin
                emb_h_reg <= imager_data_i[video_feature_pkg::XY_HBLANK_BIT];
                emb_v_reg <= imager_data_i[video_feature_pkg::XY_VBLANK_BIT];
                emb_f_reg <= imager_data_i[video_feature_pkg::XY_FIELD_BIT];
            end
        end
    end

    // Decoder state stays live so a mode switch needs no resync
    assign h_timing_o = ext_ref ? h_ref_sync : emb_h_reg;
    assign v_timing_o = ext_ref ? vref_sync : emb_v_reg;
    assign field_o    = ext_ref ? ext_field_reg : emb_f_reg;

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            video_data_o      <= 8'h00;
            video_data_oe_n_o <= 1'b1;
        end
        else
        begin
            video_data_oe_n_o <= !(hiz_sync &&
                opctl_reg[video_feature_pkg::OUTPUT_ENABLE_BIT]);
            if (opctl2_reg[video_feature_pkg::CLIP_RELAX_BIT])
                video_data_o <= limit(video_data_i,
                    video_feature_pkg::CODE_RELAX_MIN,
                    video_feature_pkg::CODE_RELAX_MAX);
            else
                video_data_o <= limit(video_data_i,
                    video_feature_pkg::CODE_BLACK,
                    video_is_chroma_i ? video_feature_pkg::CODE_CHROMA_MAX :
                    video_feature_pkg::CODE_LUMA_MAX);
        end
    end

    property p_start_runs;
        @(posedge clock_i) disable iff (rst_i)
        write_feature && reg_wdata_i[1] && !awb.busy |=> awb.busy;
    endproperty
    a_start_runs: assert property (p_start_runs)
        else $error("balancing did not start on write of 1");

    property p_zero_ignored;
        @(posedge clock_i) disable iff (rst_i)
        write_feature && !reg_wdata_i[1] && !awb.busy |=> !awb.busy;
    endproperty
    a_zero_ignored: assert property (p_zero_ignored)
        else $error("write of 0 started balancing");

    property p_idle_reads_zero;
        @(posedge clock_i) disable iff (rst_i)
        reg_read_i && reg_addr_i == 8'h05 && !awb.busy |=> !reg_rdata_o[1];
    endproperty
    a_idle_reads_zero: assert property (p_idle_reads_zero)
        else $error("start bit read 1 while idle");

    property p_hiz_gate;
        @(posedge clock_i) disable iff (rst_i)
        !opctl_reg[3] || !pin_sync_reg[2] |=> video_data_oe_n_o;
    endproperty
    a_hiz_gate: assert property (p_hiz_gate)
        else $error("outputs driven without both enables");

    property p_relax_codes;
        @(posedge clock_i) disable iff (rst_i)
        opctl2_reg[6] |=> video_data_o != 8'h00 && video_data_o != 8'hFF;
    endproperty
    a_relax_codes: assert property (p_relax_codes)
        else $error("forbidden code on output");

    property p_luma_range;
        @(posedge clock_i) disable iff (rst_i)
        // Reset leaves the output at 00; skip the edge that releases it
        !rst_i && !opctl2_reg[6] && !video_is_chroma_i |=>
            video_data_o >= 8'h10 && video_data_o <= 8'hEB;
    endproperty
    a_luma_range: assert property (p_luma_range)
        else $error("luma outside standard range");

    property p_embedded_h;
        @(posedge clock_i) disable iff (rst_i)
        !ext_ref && sync_seen ##1 !ext_ref |-> h_timing_o == $past(
            imager_data_i[4]);
    endproperty
    a_embedded_h: assert property (p_embedded_h)
        else $error("embedded timing code not followed");

    property p_ext_ignores_codes;
        @(posedge clock_i) disable iff (rst_i)
        ext_ref |->
            h_timing_o == $past(horizontal_reference_input_i, 2) &&
            v_timing_o == $past(vertical_reference_input_i, 2);
    endproperty
    a_ext_ignores_codes: assert property (p_ext_ignores_codes)
        else $error("timing not taken from reference pins");

    property p_reserved_zero;
        @(posedge clock_i) disable iff (rst_i)
        reg_read_i && reg_addr_i == 8'h07 |=> reg_rdata_o[5:0] == 6'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_red_write;
        @(posedge clock_i) disable iff (rst_i)
        reg_write_i && reg_addr_i == 8'h08 |=> red_reg == $past(reg_wdata_i);
    endproperty
    a_red_write: assert property (p_red_write)
        else $error("red balance write lost");
endmodule : video_feature_control_regs

// file: tb/video_host.sv
`timescale 1ns/1ps
module video_host (
    input  wire logic       clock_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_write_o,
    output logic            reg_read_o
);
    initial
    begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        reg_write_o = 1'b0;
        reg_read_o  = 1'b0;
    end
    // Strobe lasts one cycle, so address and data are held through it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_write_o <= 1'b1;
        @(posedge clock_i);
        reg_write_o <= 1'b0;
        reg_wdata_o <= ~d; // Stale data must not look valid
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_addr_o <= a;
        reg_read_o <= 1'b1;
        @(posedge clock_i);
        reg_read_o <= 1'b0;
        @(negedge clock_i);
        d = reg_rdata_i;
    endtask : rd
endmodule : video_host

// file: tb/video_feature_control_regs_bench.sv
`timescale 1ns/1ps
module video_feature_control_regs_bench;
    logic              clock_i = 1'b0;
    logic              rst_i = 1'b1;
    logic        [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, flags, rv;
    logic              reg_write_i, reg_read_i, gamma_enable_o;
    logic              luma_filter_disable_o, chroma_filter_disable_o;
    logic              first_line_blue_o, pixel_phase_o, h_timing_o;
    logic              v_timing_o, field_o, video_data_oe_n_o;
    logic        [7:0] red_balance_value_o, blue_balance_value_o;
    logic        [7:0] imager_data_i = 8'h80;
    logic              horizontal_reference_input_i = 1'b0;
    logic              vertical_reference_input_i = 1'b0;
    logic              high_impedance_control_pin_i = 1'b0;
    logic        [7:0] video_data_i = 8'h80;
    logic        [7:0] video_data_o;
    logic              video_is_chroma_i = 1'b0;
    logic              measure_i = 1'b0;
    logic signed [7:0] r_minus_y_i = 8'sh00;
    logic signed [7:0] b_minus_y_i = 8'sh00;
    int                num_errors = 0;
    int                samples_checked = 0;
    assign flags = {3'h0, gamma_enable_o, luma_filter_disable_o,
        chroma_filter_disable_o, pixel_phase_o, first_line_blue_o};
    always #12.5 clock_i = ~clock_i;
    video_feature_control_regs i_video_feature_control_regs (.clock_i,
        .rst_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i,
        .reg_rdata_o, .gamma_enable_o, .luma_filter_disable_o,
        .chroma_filter_disable_o, .first_line_blue_o, .pixel_phase_o,
        .red_balance_value_o, .blue_balance_value_o, .imager_data_i,
        .horizontal_reference_input_i, .vertical_reference_input_i,
        .high_impedance_control_pin_i, .h_timing_o, .v_timing_o, .field_o,
        .video_data_i, .video_is_chroma_i, .video_data_o,
        .video_data_oe_n_o, .measure_i, .r_minus_y_i, .b_minus_y_i);
    video_host i_video_host (.clock_i(clock_i), .reg_rdata_i(reg_rdata_o),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
        .reg_write_o(reg_write_i), .reg_read_o(reg_read_i));
    task automatic close_out;
        $display("Checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        i_video_host.rd(a, rv);
        chk("register", e, rv);
    endtask : rchk
    // Sample off the edge so design updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clock_i);
        @(negedge clock_i);
    endtask : settle
    task automatic vchk(input logic [7:0] d, input logic c, input logic [7:0] e);
        @(posedge clock_i);
        video_data_i      <= d;
        video_is_chroma_i <= c;
        settle(1);
        chk("video", e, video_data_o);
    endtask : vchk
    task automatic emb(input logic [7:0] xy);
        logic [7:0] seq [4];
        seq = '{8'hFF, 8'h00, 8'h00, xy};
        foreach (seq[k])
        begin
            @(posedge clock_i);
            imager_data_i <= seq[k];
        end
        @(posedge clock_i);
        imager_data_i <= 8'h80;
        settle(3);
    endtask : emb
    task automatic meas(input logic [7:0] r, input logic [7:0] b);
        @(posedge clock_i);
        r_minus_y_i <= r;
        b_minus_y_i <= b;
        measure_i   <= 1'b1;
        @(posedge clock_i);
        measure_i <= 1'b0;
        settle(5);
    endtask : meas
    initial
    begin
        repeat (20000) @(posedge clock_i);
        $display("Error timeout expected end seen hang");
        num_errors++;
        close_out();
    end
    initial
    begin
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        for (int a = 5; a < 10; a++)
            rchk(8'(a), 8'h00);
        i_video_host.wr(8'h05, 8'hFD);
        rchk(8'h05, 8'h1C);
        i_video_host.wr(8'h06, 8'hFF);
        rchk(8'h06, 8'h1F);
        chk("flags", 8'h1F, flags);
        i_video_host.wr(8'h07, 8'hFF);
        rchk(8'h07, 8'hC0);
        i_video_host.wr(8'h08, 8'hA5);
        rchk(8'h08, 8'hA5);
        chk("red", 8'hA5, red_balance_value_o);
        for (int i = 0; i < 4; i++)
        begin
            i_video_host.wr(8'h06, {4'h0, i[1], 3'h0});
            high_impedance_control_pin_i <= i[0];
            settle(4);
            chk("oe_n", 8'(!(i[1] && i[0])), 8'(video_data_oe_n_o));
        end
        i_video_host.wr(8'h07, 8'h40);
        vchk(8'h00, 1'b0, 8'h01);
        vchk(8'hFF, 1'b1, 8'hFE);
        i_video_host.wr(8'h07, 8'h00);
        vchk(8'h00, 1'b0, 8'h10);
        vchk(8'hFF, 1'b0, 8'hEB);
        vchk(8'hFF, 1'b1, 8'hF0);
        i_video_host.wr(8'h06, 8'h11);
        horizontal_reference_input_i <= 1'b1;
        emb(8'h40);
        chk("ext", 8'h05, 8'({h_timing_o, field_o, first_line_blue_o}));
        @(posedge clock_i);
        vertical_reference_input_i <= 1'b1;
        settle(5);
        chk("vref", 8'h06, 8'({v_timing_o, field_o, first_line_blue_o}));
        i_video_host.wr(8'h06, 8'h00);
        vertical_reference_input_i <= 1'b0;
        horizontal_reference_input_i <= 1'b0;
        emb(8'h30);
        chk("embedded", 8'h06, 8'({h_timing_o, v_timing_o, field_o}));
        i_video_host.wr(8'h05, 8'h02);
        rchk(8'h05, 8'h02);
        i_video_host.wr(8'h05, 8'h00);
        rchk(8'h05, 8'h02);
        meas(8'h40, 8'hC0);
        chk("red", 8'hA4, red_balance_value_o);
        chk("blue", 8'h01, blue_balance_value_o);
        meas(8'h00, 8'h00);
        rchk(8'h05, 8'h00);
        close_out();
    end
endmodule : video_feature_control_regs_bench
